// File: verilog/lcdt_timing_core.sv
`timescale 1ns/10ps
// Contract
// RULE_01 - Reset drives all outputs to supply level
// RULE_02 - Reset mode is 1:4, third bias
// RULE_03 - Reset clears banks, blink, enable, interface
// RULE_04 - Reset clears data pointer and subaddress counter
// RULE_05 - Host waits one millisecond after power-on
// RULE_06 - Half bias 1:2 closes bypass switch
// RULE_07 - Drive levels follow last mode write
// RULE_08 - Static, 1:2 half/third, 1:3, 1:4 supported
// RULE_09 - Half bias also accepted for 1:3, 1:4
// RULE_10 - Backplane count selects the drive mode
// RULE_11 - One clock source times everything
// RULE_12 - Strap low: internal oscillator, drive clock pin
// RULE_13 - Strap high: clock pin is external input
// RULE_14 - System keeps the clock always running
// RULE_15 - Frame is selected clock divided by 24
// RULE_16 - Cascaded drivers align over sync line
// RULE_17 - RAM to segment transfer follows multiplex
// RULE_18 - Holding register stable during row drive
// RULE_19 - Rows shown in sequence per mode
// RULE_20 - Modulo-24 counter wrap advances rows
// RULE_21 - Disabled display holds supply level everywhere
module lcdt_timing_core #(
    parameter int POR_CYCLES = lcdt_pkg::POR_CYCLES_DFLT,
    parameter int OSC_DIV = lcdt_pkg::OSC_DIV_DFLT
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic [lcdt_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [lcdt_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [lcdt_pkg::DATA_W-1:0] reg_rdata,
    input wire logic clock_source_strap,
    input wire logic [2:0] subaddr_pins,
    input wire logic clk_pin_i,
    output logic clk_pin_o,
    output logic clk_pin_oe,
    input wire logic sync_i,
    output logic sync_o,
    output logic sync_oe,
    output logic [2*lcdt_pkg::BP_N-1:0] backplane_outputs,
    output logic [2*lcdt_pkg::SEG_N-1:0] segment_outputs,
    output logic bias_bypass,
    output logic reset_done
);
    import lcdt_pkg::*;
    // Drive level of one electrode for the present phase
    function automatic logic [1:0] lcdt_level(input logic on, input logic is_bp,
                                              input logic phase, input logic half,
                                              input logic is_static);
        if (is_static) begin
            // Two levels only: segment on sits opposite the backplane
            return ((is_bp || !on) ^ phase) ? LVL_VLCD : LVL_VSS;
        end
        // Selected electrodes swing rail to rail, backplane and segment in antiphase
        if (on) begin
            return (phase ^ is_bp) ? LVL_VLCD : LVL_VSS;
        end
        // Idle electrodes sit on the taps; half bias folds both onto one tap
        return (half || (phase ^ is_bp)) ? LVL_LOW : LVL_HIGH;
    endfunction
    // Synchroniser chains for pins
    logic strap_s1_q, strap_s2_q;
    logic [2:0] sub_s1_q, sub_s2_q;
    logic ext_s1_q, ext_s2_q, ext_s3_q;
    logic sync_s1_q, sync_s2_q, sync_s3_q;
    // Own pull on the sync line, delayed to match the synchroniser depth
    logic own_pull1_q, own_pull2_q;
    // Configuration registers
    logic [1:0] mux_q;
    logic [1:0] blink_sel_q;
    logic bias_half_q, disp_en_q, obank_q, ibank_q;
    logic [5:0] ptr_q;
    logic [2:0] subcnt_q;
    // Storage and display path
    logic [3:0] ram_q [0:SEG_N-1];
    logic [SEG_N-1:0] hold_q;
    logic [4:0] frame_cnt_q;
    logic [1:0] row_q;
    logic [BLINK_W-1:0] blink_cnt_q;
    // Clock source
    logic [7:0] osc_cnt_q;
    logic osc_clk_q;
    logic [15:0] por_cnt_q;
    lcdt_por_t por_q;
    // Combinational helpers
    logic tick, frame_wrap, resync, advance, blank, phase, is_static;
    logic [1:0] row_d, row_last, phys_row;
    logic wr_ram, sub_match;
    // Pin synchronisers; logic reads the second stage, plus the third for clock and sync edges
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_s1_q <= 1'b0;
            strap_s2_q <= 1'b0;
            sub_s1_q <= 3'h0;
            sub_s2_q <= 3'h0;
            ext_s1_q <= 1'b0;
            ext_s2_q <= 1'b0;
            ext_s3_q <= 1'b0;
            sync_s1_q <= 1'b1;
            sync_s2_q <= 1'b1;
            sync_s3_q <= 1'b1;
        end else begin
            strap_s1_q <= clock_source_strap;
            strap_s2_q <= strap_s1_q;
            sub_s1_q <= subaddr_pins;
            sub_s2_q <= sub_s1_q;
            ext_s1_q <= clk_pin_i;
            ext_s2_q <= ext_s1_q;
            ext_s3_q <= ext_s2_q;
            sync_s1_q <= sync_i;
            sync_s2_q <= sync_s1_q;
            sync_s3_q <= sync_s2_q;
        end
    end
    // Internal oscillator: divided from clk; runs always so cascades never starve
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            osc_cnt_q <= 8'h00;
            osc_clk_q <= 1'b0;
        end else if (osc_cnt_q == 8'(OSC_DIV - 1)) begin
            osc_cnt_q <= 8'h00;
            osc_clk_q <= !osc_clk_q;
        end else begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end
    end
    // One timing tick from whichever source the strap selects
    assign tick = strap_s2_q ? (ext_s2_q && !ext_s3_q) // RULE_13
        : ((osc_cnt_q == 8'(OSC_DIV - 1)) && !osc_clk_q); // RULE_11
    // Clock pin driven only when the internal oscillator is in use
    assign clk_pin_oe = !strap_s2_q; // RULE_12
    assign clk_pin_o = osc_clk_q; // RULE_12
    // Power-on wait; host must hold off until reset_done
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            por_q <= POR_WAIT;
            por_cnt_q <= 16'h0000;
        end else begin
            case (por_q)
                POR_WAIT: begin
                    if (por_cnt_q == 16'(POR_CYCLES - 1)) begin
                        por_q <= POR_RUN;
                    end else begin
                        por_cnt_q <= por_cnt_q + 16'h0001;
                    end
                end
                POR_RUN: por_q <= POR_RUN;
                default: por_q <= POR_WAIT;
            endcase
        end
    end
    assign reset_done = (por_q == POR_RUN); // RULE_05
    // Register writes; mode and control reset to their power-on values
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mux_q <= MUX_RST; // RULE_02
            bias_half_q <= BIAS_HALF_RST; // RULE_02
            disp_en_q <= 1'b0; // RULE_03
            blink_sel_q <= 2'h0; // RULE_03
            obank_q <= 1'b0; // RULE_03
            ibank_q <= 1'b0; // RULE_03
        end else if (reg_wr && reg_addr == REG_MODE) begin
            // Every combination is accepted, half bias with 1:3 or 1:4 too
            mux_q <= reg_wdata[MODE_MUX_LSB +: 2]; // RULE_07 RULE_09 RULE_10
            bias_half_q <= reg_wdata[MODE_BIAS_BIT]; // RULE_08
        end else if (reg_wr && reg_addr == REG_CTRL) begin
            disp_en_q <= reg_wdata[CTRL_EN_BIT];
            blink_sel_q <= reg_wdata[CTRL_BLINK_LSB +: 2];
            obank_q <= reg_wdata[CTRL_OBANK_BIT];
            ibank_q <= reg_wdata[CTRL_IBANK_BIT];
        end
    end
    // Data writes only land when the cascade subaddress matches the pins
    assign wr_ram = reg_wr && reg_addr == REG_RAMDATA;
    assign sub_match = (subcnt_q == sub_s2_q);
    // Data pointer and subaddress counter; overflow hands on to next device
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ptr_q <= PTR_RST; // RULE_04
            subcnt_q <= SUBADDR_RST; // RULE_04
        end else if (reg_wr && reg_addr == REG_PTR) begin
            ptr_q <= (reg_wdata[5:0] > RAM_LAST) ? RAM_LAST : reg_wdata[5:0];
        end else if (reg_wr && reg_addr == REG_SUBADDR) begin
            subcnt_q <= reg_wdata[2:0];
        end else if (wr_ram) begin
            if (ptr_q == RAM_LAST) begin
                ptr_q <= PTR_RST;
                subcnt_q <= subcnt_q + 3'h1;
            end else begin
                ptr_q <= ptr_q + 6'h01;
            end
        end
    end
    // Display RAM: bits stored per mode, input bank shifts static and 1:2 upward
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < SEG_N; i++) begin
                ram_q[i] <= 4'h0;
            end
        end else if (wr_ram && sub_match) begin
            case (mux_q)
                MUX_STATIC: ram_q[ptr_q][ibank_q ? 2 : 0] <= reg_wdata[0];
                MUX_2: begin
                    if (ibank_q) begin
                        ram_q[ptr_q][3:2] <= reg_wdata[1:0];
                    end else begin
                        ram_q[ptr_q][1:0] <= reg_wdata[1:0];
                    end
                end
                // Row 3 left unchanged in three-row mode
                MUX_3: ram_q[ptr_q][2:0] <= reg_wdata[2:0];
                default: ram_q[ptr_q] <= reg_wdata[3:0];
            endcase
        end
    end
    // Row sequencing: last row depends on backplane count
    assign row_last = mux_q;
    assign frame_wrap = tick && (frame_cnt_q == FRAME_LAST);
    // A falling line counts only if we were not pulling it; our own pulse reaches the
    // second stage two clocks late and would otherwise restart us over and over
    assign resync = !sync_s2_q && sync_s3_q && !own_pull2_q; // RULE_16
    assign advance = frame_wrap || resync;
    assign row_d = (resync || row_q >= row_last) ? 2'h0 : row_q + 2'h1; // RULE_19
    // Output bank picks row 2 in static mode and rows 2 and 3 in 1:2 mode
    assign phys_row = (obank_q && mux_q <= MUX_2) ? (row_d + BANK_OFS) : row_d;
    // Frame divider and row counter
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_cnt_q <= 5'h00; // RULE_20
            row_q <= 2'h0;
        end else if (resync) begin
            frame_cnt_q <= 5'h00; // RULE_16
            row_q <= 2'h0; // RULE_16
        end else if (tick) begin
            frame_cnt_q <= frame_wrap ? 5'h00 : frame_cnt_q + 5'h01; // RULE_15 RULE_20
            if (frame_wrap) begin
                row_q <= row_d; // RULE_20
            end
        end
    end
    // Holding register loaded only at row change, so the row never tears
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_q <= '0;
        end else if (advance) begin
            for (int i = 0; i < SEG_N; i++) begin
                hold_q[i] <= ram_q[i][phys_row]; // RULE_17 RULE_18
            end
        end
    end
    // Sync line: open drain, pulled low during our own frame start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sync_oe <= 1'b0;
            own_pull1_q <= 1'b0;
            own_pull2_q <= 1'b0;
        end else begin
            sync_oe <= (row_q == 2'h0) && (frame_cnt_q == 5'h00); // RULE_16
            own_pull1_q <= sync_oe;
            own_pull2_q <= own_pull1_q;
        end
    end
    assign sync_o = 1'b0;
    // Blink counter in complete row sequences; blanking only hides segments
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            blink_cnt_q <= '0;
        end else if (frame_wrap && row_d == 2'h0) begin
            blink_cnt_q <= blink_cnt_q + 8'h01;
        end
    end
    assign blank = (blink_sel_q != 2'h0) && blink_cnt_q[BLINK_W - 1 - int'(blink_sel_q)];

    assign phase = (frame_cnt_q >= FRAME_HALF);
    assign is_static = (mux_q == MUX_STATIC);
    // Backplane levels; static drives all four alike
    generate
        for (genvar b = 0; b < BP_N; b++) begin : g_bp
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    backplane_outputs[2*b +: 2] <= LVL_VLCD; // RULE_01
                end else if (!disp_en_q) begin
                    backplane_outputs[2*b +: 2] <= LVL_VLCD; // RULE_21
                end else begin
                    backplane_outputs[2*b +: 2] <= lcdt_level(
                        is_static || (2'(b) == row_q) || (mux_q == MUX_3 && b == 3 && row_q == 2'h1)
                        || (mux_q == MUX_2 && 2'(b & 1) == row_q),
                        1'b1, phase, bias_half_q, is_static); // RULE_07 RULE_10
                end
            end
        end
        // Segment levels from the holding register
        for (genvar s = 0; s < SEG_N; s++) begin : g_seg
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    segment_outputs[2*s +: 2] <= LVL_VLCD; // RULE_01
                end else if (!disp_en_q) begin
                    segment_outputs[2*s +: 2] <= LVL_VLCD; // RULE_21
                end else begin
                    segment_outputs[2*s +: 2] <= lcdt_level(hold_q[s] && !blank, 1'b0,
                        phase, bias_half_q, is_static); // RULE_17 RULE_07
                end
            end
        end
    endgenerate
    // Bias divider middle-resistor bypass
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            bias_bypass <= 1'b0;
        end else begin
            bias_bypass <= bias_half_q && (mux_q == MUX_2); // RULE_06
        end
    end
    // Read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                REG_MODE: reg_rdata <= {5'h00, bias_half_q, mux_q};
                REG_CTRL: reg_rdata <= {3'h0, ibank_q, obank_q, blink_sel_q, disp_en_q};
                REG_PTR: reg_rdata <= {2'h0, ptr_q};
                REG_SUBADDR: reg_rdata <= {5'h00, subcnt_q};
                REG_RAMDATA: reg_rdata <= {4'h0, ram_q[ptr_q]};
                REG_STATUS: reg_rdata <= {reset_done, strap_s2_q, row_q, 4'h0};
                default: reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

    chk_disabled_all_vlcd: assert property (@(posedge clk) disable iff (!rstn) // RULE_21
        !disp_en_q |=> (&backplane_outputs) && (&segment_outputs))
        else $error("outputs not at supply level while disabled");
    chk_frame_wrap_zero: assert property (@(posedge clk) disable iff (!rstn) // RULE_15
        (tick && frame_cnt_q == FRAME_LAST && !resync) |=> frame_cnt_q == 5'h00)
        else $error("frame divider did not wrap after 24 ticks");
    chk_row_advance_wrap: assert property (@(posedge clk) disable iff (!rstn) // RULE_20
        (frame_wrap && !resync) |=> row_q == ($past(row_q) >= $past(mux_q) ? 2'h0 : $past(row_q) + 2'h1))
        else $error("row did not advance on frame wrap");
    chk_row_in_range: assert property (@(posedge clk) disable iff (!rstn) // RULE_19
        $rose(frame_wrap) ##1 $stable(mux_q) |-> row_q <= mux_q)
        else $error("row beyond active backplanes");
    chk_bypass_switch: assert property (@(posedge clk) disable iff (!rstn) // RULE_06
        ##1 bias_bypass == $past(bias_half_q && mux_q == MUX_2))
        else $error("bias bypass switch wrong");
    chk_clock_direction: assert property (@(posedge clk) disable iff (!rstn) // RULE_12
        $past(rstn, 2) |-> clk_pin_oe == !$past(clock_source_strap, 2))
        else $error("clock pin direction does not follow strap");
    chk_hold_stable: assert property (@(posedge clk) disable iff (!rstn) // RULE_18
        !advance |=> $stable(hold_q))
        else $error("holding register changed mid row");
    chk_mode_follow: assert property (@(posedge clk) disable iff (!rstn) // RULE_07
        (reg_wr && reg_addr == REG_MODE) |=> mux_q == $past(reg_wdata[1:0])
        ##1 bias_bypass == $past(bias_half_q && mux_q == MUX_2))
        else $error("mode write not taken");
    chk_ptr_overflow: assert property (@(posedge clk) disable iff (!rstn) // RULE_04
        (wr_ram && ptr_q == RAM_LAST) |=> ptr_q == PTR_RST && subcnt_q == $past(subcnt_q) + 3'h1)
        else $error("pointer overflow mishandled");
    chk_sync_drive: assert property (@(posedge clk) disable iff (!rstn) // RULE_16
        (row_q == 2'h0 && frame_cnt_q == 5'h00) |=> sync_oe && !sync_o)
        else $error("sync line not pulled at frame start");
endmodule // lcdt_timing_core

// File: verilog/lcdt_pkg.sv
package lcdt_pkg;
    // Register bus widths
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;

    // Register offsets
    localparam logic [3:0] REG_MODE = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h1;
    localparam logic [3:0] REG_PTR = 4'h2;
    localparam logic [3:0] REG_SUBADDR = 4'h3;
    localparam logic [3:0] REG_RAMDATA = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h5;

    // Field positions
    localparam int MODE_MUX_LSB = 0;
    localparam int MODE_BIAS_BIT = 2;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_BLINK_LSB = 1;
    localparam int CTRL_OBANK_BIT = 3;
    localparam int CTRL_IBANK_BIT = 4;

    // Drive mode codes held in the mode register
    localparam logic [1:0] MUX_STATIC = 2'h0;
    localparam logic [1:0] MUX_2 = 2'h1;
    localparam logic [1:0] MUX_3 = 2'h2;
    localparam logic [1:0] MUX_4 = 2'h3;

    // Values after reset
    localparam logic [1:0] MUX_RST = MUX_4;
    localparam logic BIAS_HALF_RST = 1'b0;
    localparam logic [5:0] PTR_RST = 6'h00;
    localparam logic [2:0] SUBADDR_RST = 3'h0;

    // Display geometry
    localparam int SEG_N = 40;
    localparam int BP_N = 4;
    localparam logic [5:0] RAM_LAST = 6'h27;
    localparam logic [1:0] BANK_OFS = 2'h2;

    // Frame divider: fixed ratio of the selected clock
    localparam logic [4:0] FRAME_LAST = 5'h17;
    localparam logic [4:0] FRAME_HALF = 5'h0c;

    // Blink: row-sequence counter bits used for slow, medium and fast blink
    localparam int BLINK_W = 8;

    // Timing
    localparam int CLK_NS = 25;
    localparam int POR_TIME_US = 1000;
    localparam int POR_CYCLES_DFLT = (POR_TIME_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int OSC_DIV_DFLT = 16;

    // Drive level codes: supply ground, lower and upper bias taps, LCD supply
    localparam logic [1:0] LVL_VSS = 2'h0;
    localparam logic [1:0] LVL_LOW = 2'h1;
    localparam logic [1:0] LVL_HIGH = 2'h2;
    localparam logic [1:0] LVL_VLCD = 2'h3;

    // Power-on sequencer
    typedef enum logic {POR_WAIT, POR_RUN} lcdt_por_t;
endpackage

// File: verif/lcdt_cascade_model.sv
`timescale 1ns/10ps
// Far side: a cascaded driver that shares the sync line and feeds the clock pin
module lcdt_cascade_model #(
    parameter int EXT_HALF_NS = 100
) (
    dut_sync_o,
    dut_sync_oe,
    pull_req,
    sync_line,
    ext_clk
);
    input wire logic dut_sync_o;
    input wire logic dut_sync_oe;
    input wire logic pull_req;
    output logic sync_line;
    output logic ext_clk;
    // Open-drain line with a pull-up: low while any party pulls it
    assign sync_line = !((dut_sync_oe && !dut_sync_o) || pull_req);
    // Free-running clock; it never stops, so the panel never sees a DC state
    initial begin
        ext_clk = 1'b0;
        #7;
        forever #(EXT_HALF_NS) ext_clk = ~ext_clk;
    end
endmodule // lcdt_cascade_model

// File: verif/tb_top.sv
`timescale 1ns/10ps
module tb_top;
    import lcdt_pkg::*;
    localparam int OSC_DIV_TB = 2; // Short divider keeps frames brief
    localparam int TICK = 2 * OSC_DIV_TB; // Clocks per internal tick
    logic clk, rstn, reg_wr, reg_rd, strap, pull_req, clk_o, clk_oe, sync_o, sync_oe;
    logic bias_bypass, reset_done, sync_line, ext_clk;
    logic [ADDR_W-1:0] reg_addr;
    logic [DATA_W-1:0] reg_wdata, reg_rdata, d;
    logic [2:0] subaddr_pins;
    logic [2*BP_N-1:0] bp;
    logic [2*SEG_N-1:0] seg;
    int fail_count, cmp_count, p;
    lcdt_timing_core #(.POR_CYCLES(20), .OSC_DIV(OSC_DIV_TB)) lcdt_timing_core_i (
        .clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .clock_source_strap(strap), .subaddr_pins(subaddr_pins), .clk_pin_i(ext_clk),
        .clk_pin_o(clk_o), .clk_pin_oe(clk_oe), .sync_i(sync_line), .sync_o(sync_o),
        .sync_oe(sync_oe), .backplane_outputs(bp), .segment_outputs(seg),
        .bias_bypass(bias_bypass), .reset_done(reset_done));
    lcdt_cascade_model lcdt_cascade_model_i (.dut_sync_o(sync_o), .dut_sync_oe(sync_oe),
        .pull_req(pull_req), .sync_line(sync_line), .ext_clk(ext_clk));
    // Clock at 40 MHz
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    // Verdict and end of run
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Compare a seen value with the expected one
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe; data stand only in the following cycle
    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Wait for a rising sync_oe; a bound guards against a dead sequencer
    task automatic wait_rise(output int n);
        logic prev;
        prev = 1'b1;
        for (n = 1; n < 2000; n++) begin
            @(posedge clk);
            #1;
            if (sync_oe === 1'b1 && prev === 1'b0) return;
            prev = sync_oe;
        end
        fail_count++;
        $display("mismatch at %0t: sync pulse missing", $time);
        test_done();
    endtask
    // Clocks between two frame-sequence starts, second interval after a change
    task automatic period(output int n);
        wait_rise(n);
        wait_rise(n);
        wait_rise(n);
    endtask
    initial begin
        rstn = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        strap = 1'b0;
        pull_req = 1'b0;
        subaddr_pins = 3'h0;
        fail_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        cyc(1);
        check(bp, {8{1'b1}});
        check(seg, {80{1'b1}});
        check(bias_bypass, 1'b0);
        // Host waits for the power-on wait before any access
        for (p = 0; p < 100 && reset_done !== 1'b1; p++) cyc(1);
        check(reset_done, 1'b1);
        rd(REG_MODE, d);
        check(d, 8'h03);
        rd(REG_CTRL, d);
        check(d, 8'h00);
        rd(REG_PTR, d);
        check(d, 8'h00);
        rd(REG_SUBADDR, d);
        check(d, 8'h00);
        rd(REG_STATUS, d);
        check(d & 8'hc0, 8'h80);
        // Every mode with both biases; bypass only for half bias at 1:2
        for (int m = 0; m < 4; m++) begin
            for (int h = 0; h < 2; h++) begin
                wr(REG_MODE, {5'h00, h[0], m[1:0]});
                cyc(2);
                check(bias_bypass, (h == 1 && m == 1));
                rd(REG_MODE, d);
                check(d, {5'h00, h[0], m[1:0]});
            end
        end
        // Frame sequence length per mode from the internal clock
        wr(REG_CTRL, 8'h01);
        for (int m = 0; m < 4; m++) begin
            wr(REG_MODE, {6'h00, m[1:0]});
            period(p);
            check(p, (m + 1) * 24 * TICK);
        end
        wait_rise(p);
        cyc(2 * 24 * TICK + 10);
        rd(REG_STATUS, d);
        check(d[5:4], 2'h2);
        check(bp !== 8'hff, 1'b1);
        // A cascade partner pulls sync mid-sequence; rows restart at 0
        pull_req <= 1'b1;
        cyc(3);
        pull_req <= 1'b0;
        cyc(4);
        rd(REG_STATUS, d);
        check(d[5:4], 2'h0);
        wr(REG_CTRL, 8'h00);
        cyc(2);
        check(bp, {8{1'b1}});
        check(seg, {80{1'b1}});
        // RAM store, subaddress mismatch, pointer saturation and wrap
        wr(REG_PTR, 8'h05);
        wr(REG_RAMDATA, 8'h0a);
        wr(REG_PTR, 8'h05);
        rd(REG_RAMDATA, d);
        check(d, 8'h0a);
        wr(REG_SUBADDR, 8'h01);
        wr(REG_PTR, 8'h07);
        wr(REG_RAMDATA, 8'h0f);
        rd(REG_PTR, d);
        check(d, 8'h08);
        wr(REG_PTR, 8'h07);
        rd(REG_RAMDATA, d);
        check(d, 8'h00);
        wr(REG_PTR, 8'h3f);
        rd(REG_PTR, d);
        check(d, 8'h27);
        wr(REG_RAMDATA, 8'h00);
        rd(REG_PTR, d);
        check(d, 8'h00);
        rd(REG_SUBADDR, d);
        check(d, 8'h02);
        rd(4'hf, d);
        check(d, 8'h00);
        // External clock on the pin: 8 clocks per tick, 1:2 mode
        wr(REG_CTRL, 8'h01);
        wr(REG_MODE, 8'h01);
        strap <= 1'b1;
        cyc(4);
        check(clk_oe, 1'b0);
        rd(REG_STATUS, d);
        check(d[6], 1'b1);
        period(p);
        check(p, 2 * 24 * 8);
        strap <= 1'b0;
        cyc(4);
        check(clk_oe, 1'b1);
        d[0] = clk_o;
        cyc(OSC_DIV_TB);
        check(clk_o, !d[0]);
        test_done();
    end
endmodule // tb_top
